/* ifd_pkg.sv */
// Shared constants and types for the instruction format decoder.
package ifd_pkg;

  // ****************************************************************
  // Instruction word layout (bit 0 of the format is bit 31 here)
  // ****************************************************************
  localparam int IFD_OP_MSB   = 31;
  localparam int IFD_OP_LSB   = 24;
  localparam int IFD_F1_MSB   = 23;
  localparam int IFD_F1_LSB   = 20;
  localparam int IFD_F2_MSB   = 19;
  localparam int IFD_F2_LSB   = 16;
  localparam int IFD_B16      = 15;
  localparam int IFD_B17      = 14;
  localparam int IFD_B18      = 13;
  localparam int IFD_B19      = 12;
  localparam int IFD_D14_W    = 14;
  localparam int IFD_D15_W    = 15;
  localparam int IFD_WORD_W   = 32;

  // ****************************************************************
  // Opcode ranges that pick the format family
  // ****************************************************************
  localparam logic [7:0] IFD_SHORT_LO = 8'h20;
  localparam logic [7:0] IFD_SHORT_HI = 8'h2f;
  localparam logic [7:0] IFD_RX_LO    = 8'h40;
  localparam logic [7:0] IFD_RX_HI    = 8'hbf;
  localparam logic [7:0] IFD_RI2_LO   = 8'hf8;

  // Conditional branch opcodes: a register form, a short form and two indexed forms.
  localparam logic [7:0] IFD_CBR_REG   = 8'h02;
  localparam logic [7:0] IFD_CBR_SHORT = 8'h22;
  localparam logic [7:0] IFD_CBR_RXT   = 8'h42;
  localparam logic [7:0] IFD_CBR_RXF   = 8'h43;

  // ****************************************************************
  // Lengths in halfwords and zero constants
  // ****************************************************************
  localparam logic [1:0]  IFD_LEN_1HW  = 2'h1;
  localparam logic [1:0]  IFD_LEN_2HW  = 2'h2;
  localparam logic [1:0]  IFD_LEN_3HW  = 2'h3;
  localparam logic [31:0] IFD_ZERO32   = 32'h0000_0000;
  localparam logic [3:0]  IFD_ZERO4    = 4'h0;

  // One-hot format codes; illegal is the reset value.
  typedef enum logic [7:0] {
    IFD_FMT_REGREG = 8'h01,
    IFD_FMT_SHORT  = 8'h02,
    IFD_FMT_IDXABS = 8'h04,
    IFD_FMT_IDXREL = 8'h08,
    IFD_FMT_DBLIDX = 8'h10,
    IFD_FMT_RI1    = 8'h20,
    IFD_FMT_RI2    = 8'h40,
    IFD_FMT_ILL    = 8'h80
  } ifd_fmt_t;

endpackage

/* ifd_fmt_class.sv */
// Combinational format and length classifier for one instruction word.
`timescale 1ns/100ps
`default_nettype none

module ifd_fmt_class (
  input  wire logic [31:0]       i_instr,  // Instruction, first halfword high.
  output var  ifd_pkg::ifd_fmt_t o_fmt,    // One-hot format.
  output var  logic [1:0]        o_len_hw  // Length in halfwords.
);
  import ifd_pkg::*;

  logic [7:0] op;
  assign op = i_instr[IFD_OP_MSB:IFD_OP_LSB];

  // ****************************************************************
  // Format selection
  // ****************************************************************
  // Opcode picks the family; bits 16 to 19 split the indexed family.
  always_comb begin
    o_fmt    = IFD_FMT_ILL;
    o_len_hw = IFD_LEN_1HW;
    if (op < IFD_RX_LO) begin
      o_fmt = (op >= IFD_SHORT_LO && op <= IFD_SHORT_HI) ? IFD_FMT_SHORT : IFD_FMT_REGREG;
    end else if (op <= IFD_RX_HI) begin
      o_len_hw = IFD_LEN_2HW;
      if (i_instr[IFD_B16]) begin
        o_fmt = IFD_FMT_IDXREL;
      end else if (!i_instr[IFD_B17]) begin
        o_fmt = IFD_FMT_IDXABS;
      end else if (!i_instr[IFD_B18] && !i_instr[IFD_B19]) begin
        o_fmt    = IFD_FMT_DBLIDX;
        o_len_hw = IFD_LEN_3HW;
      end else begin
        // Bit 18 or 19 set with bit 17 is no defined layout.
        o_fmt    = IFD_FMT_ILL;
        o_len_hw = IFD_LEN_1HW;
      end
    end else if (op < IFD_RI2_LO) begin
      o_fmt    = IFD_FMT_RI1;
      o_len_hw = IFD_LEN_2HW;
    end else begin
      o_fmt    = IFD_FMT_RI2;
      o_len_hw = IFD_LEN_3HW;
    end
  end

endmodule
`default_nettype wire

/* ifd_decoder.sv */
// Two-stage decoder for register, short and single-index instruction formats.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Register format: opcode bits 0:7, first register 8:11, second register 12:15.
// - Register format reads operands from registers named by both fields.
// - Short form: opcode 0:7, first register 8:11, short immediate 12:15.
// - Short form uses first register and unsigned immediate 0 to 15.
// - Absolute indexed: index 12:15, bits 16,17 zero, displacement 18:31.
// - Absolute address is index contents plus unsigned 14-bit displacement.
// - Relative indexed format is recognised by bit 16 set.
// - Relative displacement of 15 bits is sign extended, added to index.
// - Relative address also adds address of next sequential instruction.
// - Negative displacement is two's complement, giving a backward offset.
// - Branches decode in register, short and indexed formats, target formed as for operands.
// - Conditional branches use first field as mask tested against condition code.
// - Double indexed format: bit 16 clear, bit 17 set, bits 18:19 clear.
// - Location counter lowest bit is always zero.
module ifd_decoder (
  input  wire logic              i_mclk,          // Processor clock, 25 MHz.
  input  wire logic              i_reset,         // Synchronous reset, high.
  input  wire logic              i_valid,         // Instruction word present.
  input  wire logic [31:0]       i_instr,         // First halfword in 31:16.
  input  wire logic [31:0]       i_loc,           // Address of this instruction.
  input  wire logic [31:0]       i_xreg_data,     // Contents of o_x_sel register.
  input  wire logic [3:0]        i_cc,            // Condition code.
  output var  logic [3:0]        o_x_sel,         // Index register select.
  output var  logic              o_valid,         // Decode result present.
  output var  ifd_pkg::ifd_fmt_t o_format,        // One-hot format.
  output var  logic [1:0]        o_len_hw,        // Length in halfwords.
  output var  logic [7:0]        o_opcode,        // Operation code.
  output var  logic [3:0]        o_first_sel,     // First operand register.
  output var  logic [3:0]        o_second_sel,    // Second operand register.
  output var  logic              o_use_second,    // Second operand from register.
  output var  logic [31:0]       o_short_imm,     // Short immediate, zero extended.
  output var  logic [31:0]       o_ea,            // Second operand address.
  output var  logic              o_ea_valid,      // o_ea holds an address.
  output var  logic              o_cond_branch,   // Conditional branch.
  output var  logic [3:0]        o_branch_mask,   // Mask of a conditional branch.
  output var  logic              o_branch_take    // Mask meets condition code.
);
  import ifd_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    // Stage one: fields captured, index register being read.
    logic                    s1_v;
    ifd_fmt_t                s1_fmt;
    logic [1:0]              s1_len;
    logic [7:0]              s1_op;
    logic [3:0]              s1_f1;
    logic [3:0]              s1_f2;
    logic [IFD_D15_W-1:0]    s1_disp;
    logic [31:0]             s1_next;
    // Stage two: outputs.
    logic                    v;
    ifd_fmt_t                fmt;
    logic [1:0]              len;
    logic [7:0]              op;
    logic [3:0]              first;
    logic [3:0]              second;
    logic                    use_second;
    logic [31:0]             imm;
    logic [31:0]             ea;
    logic                    ea_v;
    logic                    cbr;
    logic [3:0]              mask;
    logic                    take;
  } ifd_state_t;

  ifd_state_t st_q;
  ifd_state_t st_d;

  ifd_fmt_t   cls_fmt;
  logic [1:0] cls_len;

  ifd_fmt_class u_class (
    .i_instr  (i_instr),
    .o_fmt    (cls_fmt),
    .o_len_hw (cls_len)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Address forming waits a cycle so the index register can be read
  // from the select that stage one drives; this costs latency, not rate.
  logic [31:0] loc_even;
  logic [31:0] xval;
  logic [31:0] d14_ext;
  logic [31:0] d15_ext;
  logic        is_cbr;

  always_comb begin
    st_d     = st_q;
    loc_even = {i_loc[31:1], 1'b0};
    xval     = (st_q.s1_f2 == IFD_ZERO4) ? IFD_ZERO32 : i_xreg_data;
    d14_ext  = {{(IFD_WORD_W - IFD_D14_W){1'b0}}, st_q.s1_disp[IFD_D14_W-1:0]};
    d15_ext  = {{(IFD_WORD_W - IFD_D15_W){st_q.s1_disp[IFD_D15_W-1]}},
                st_q.s1_disp};
    is_cbr   = (st_q.s1_op == IFD_CBR_REG) || (st_q.s1_op == IFD_CBR_SHORT) ||
               (st_q.s1_op == IFD_CBR_RXT) || (st_q.s1_op == IFD_CBR_RXF);

    // Stage one captures the word fields.
    st_d.s1_v    = i_valid;
    st_d.s1_fmt  = cls_fmt;
    st_d.s1_len  = cls_len;
    st_d.s1_op   = i_instr[IFD_OP_MSB:IFD_OP_LSB];
    st_d.s1_f1   = i_instr[IFD_F1_MSB:IFD_F1_LSB];
    st_d.s1_f2   = i_instr[IFD_F2_MSB:IFD_F2_LSB];
    st_d.s1_disp = i_instr[IFD_D15_W-1:0];
    st_d.s1_next = loc_even + {29'h0, cls_len, 1'b0};

    // Stage two forms operands and addresses.
    st_d.v      = st_q.s1_v;
    st_d.fmt    = st_q.s1_fmt;
    st_d.len    = st_q.s1_len;
    st_d.op     = st_q.s1_op;
    st_d.first      = st_q.s1_f1;
    st_d.second     = st_q.s1_f2;
    st_d.use_second = (st_q.s1_fmt == IFD_FMT_REGREG);
    st_d.imm    = IFD_ZERO32;
    st_d.ea     = IFD_ZERO32;
    st_d.ea_v   = 1'b0;
    case (st_q.s1_fmt)
      IFD_FMT_SHORT: begin
        st_d.imm = {28'h0, st_q.s1_f2};
      end
      IFD_FMT_IDXABS: begin
        st_d.ea   = xval + d14_ext;
        st_d.ea_v = 1'b1;
      end
      IFD_FMT_IDXREL: begin
        st_d.ea   = xval + d15_ext + st_q.s1_next;
        st_d.ea_v = 1'b1;
      end
      default: begin
        // Other formats carry their operands beyond this decoder.
        st_d.ea_v = 1'b0;
      end
    endcase

    // The same forms serve branch targets, so only the mask is special.
    st_d.cbr  = st_q.s1_v && is_cbr;
    st_d.mask = is_cbr ? st_q.s1_f1 : IFD_ZERO4;
    st_d.take = is_cbr && ((st_q.s1_f1 & i_cc) != IFD_ZERO4);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q <= '{s1_fmt: IFD_FMT_ILL, fmt: IFD_FMT_ILL, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a field of the state register.
  assign o_x_sel       = st_q.s1_f2;
  assign o_valid       = st_q.v;
  assign o_format      = st_q.fmt;
  assign o_len_hw      = st_q.len;
  assign o_opcode      = st_q.op;
  assign o_first_sel   = st_q.first;
  assign o_second_sel  = st_q.second;
  assign o_use_second  = st_q.use_second;
  assign o_short_imm   = st_q.imm;
  assign o_ea          = st_q.ea;
  assign o_ea_valid    = st_q.ea_v;
  assign o_cond_branch = st_q.cbr;
  assign o_branch_mask = st_q.mask;
  assign o_branch_take = st_q.take;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_taken;
    i_valid ##1 1'b1;
  endsequence

  sequence s_rx_taken;
    i_valid && (i_instr[IFD_OP_MSB:IFD_OP_LSB] >= IFD_RX_LO) &&
    (i_instr[IFD_OP_MSB:IFD_OP_LSB] <= IFD_RX_HI) ##1 1'b1;
  endsequence

  a_valid_latency: assert property (s_taken |=> o_valid)
    else $error("Decode result missing two cycles after an instruction.");

  a_regreg_fields: assert property (s_taken |=> (o_format == IFD_FMT_REGREG) |->
      (o_first_sel == $past(i_instr[23:20], 2)) &&
      (o_second_sel == $past(i_instr[19:16], 2)) && o_use_second)
    else $error("Register format fields wrong.");

  a_short_imm: assert property (s_taken |=> (o_format == IFD_FMT_SHORT) |->
      (o_short_imm == {28'h0, $past(i_instr[19:16], 2)}) && !o_use_second)
    else $error("Short immediate wrong.");

  a_rx_select: assert property (s_rx_taken |=>
      (o_format == ($past(i_instr[15], 2) ? IFD_FMT_IDXREL :
       !$past(i_instr[14], 2) ? IFD_FMT_IDXABS :
       ($past(i_instr[13:12], 2) == 2'h0) ? IFD_FMT_DBLIDX : IFD_FMT_ILL)))
    else $error("Indexed format chosen wrongly.");

  a_abs_addr: assert property (s_taken |=> (o_format == IFD_FMT_IDXABS) |->
      o_ea == (($past(i_instr[19:16], 2) == 4'h0 ? 32'h0 : $past(i_xreg_data)) +
               {18'h0, $past(i_instr[13:0], 2)}))
    else $error("Absolute indexed address wrong.");

  a_rel_addr: assert property (s_taken |=> (o_format == IFD_FMT_IDXREL) |->
      o_ea == (($past(i_instr[19:16], 2) == 4'h0 ? 32'h0 : $past(i_xreg_data)) +
               {{17{$past(i_instr[14], 2)}}, $past(i_instr[14:0], 2)} +
               {$past(i_loc[31:1], 2), 1'b0} + 32'h4))
    else $error("Relative indexed address wrong.");

  a_next_even: assert property (st_q.s1_v |-> !st_q.s1_next[0])
    else $error("Next location counter is odd.");

  a_mask_test: assert property (o_cond_branch |->
      (o_branch_take == ((o_branch_mask & $past(i_cc)) != 4'h0)) &&
      (o_branch_mask == o_first_sel))
    else $error("Branch mask test wrong.");

  a_len_code: assert property (o_valid |->
      (o_len_hw == ((o_format inside {IFD_FMT_DBLIDX, IFD_FMT_RI2}) ? 2'h3 :
       (o_format inside {IFD_FMT_IDXABS, IFD_FMT_IDXREL, IFD_FMT_RI1}) ? 2'h2 : 2'h1)))
    else $error("Instruction length wrong.");

endmodule
`default_nettype wire

/* ifd_notes_end.sv */
// Holds no code; the decoder and its helpers live in their own files.

/* ifd_xreg_model.sv */
// Behavioural index register file that answers the decoder's register reads.
`timescale 1ns/100ps
`default_nettype none

module ifd_xreg_model (
  input  wire logic [3:0]  i_sel,   // Register select from the decoder.
  input  wire logic [31:0] i_bias,  // Pattern that each register holds, XORed with its number.
  output var  logic [31:0] o_data   // Contents of the selected register.
);
  // The read is combinational because the decoder sums it in the cycle it selects.
  always_comb begin
    o_data = i_bias ^ {28'h0, i_sel};
  end
endmodule

`default_nettype wire

/* test_instr_format_decoder.sv */
// Self-checking bench for the instruction format decoder.
`timescale 1ns/100ps
`default_nettype none

module test_instr_format_decoder;
  import ifd_pkg::*;
  typedef struct {
    logic        vld;
    logic [31:0] ins;
    logic [31:0] loc;
    logic [31:0] bias;
    logic [3:0]  cc;
  } ifd_tb_item_t;
  logic         i_mclk, i_reset, i_valid, o_valid, o_use_second;
  logic         o_ea_valid, o_cond_branch, o_branch_take;
  logic [31:0]  i_instr, i_loc, xdata, bias, lfsr, o_short_imm, o_ea;
  logic [3:0]   i_cc, o_x_sel, o_first_sel, o_second_sel, o_branch_mask;
  logic [1:0]   o_len_hw;
  logic [7:0]   o_opcode;
  ifd_fmt_t     o_format;
  int           n_fail, check_count;
  ifd_tb_item_t q[$];
  localparam logic [31:0] EX_W [16] = '{32'h245e_0000, 32'h0865_0000, 32'h4050_1000,
    32'h4c56_0ff2, 32'h4050_8004, 32'h4300_8004, 32'hc890_8000, 32'hf8a0_0000,
    32'h4050_ffe4, 32'h4056_ffd2, 32'h5870_4001, 32'h4300_ffbc, 32'h4012_6000,
    32'h4001_c000, 32'h0273_0000, 32'h22a5_0000};
  localparam logic [31:0] EX_L [16] = '{32'h0, 32'h2, 32'h4, 32'h8, 32'hc, 32'h10,
    32'h18, 32'h20, 32'h2c, 32'h30, 32'h34, 32'h41, 32'h44, 32'h48, 32'h4c, 32'h4e};

  ifd_decoder uut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_valid(i_valid), .i_instr(i_instr), .i_loc(i_loc), .i_xreg_data(xdata),
    .i_cc(i_cc), .o_x_sel(o_x_sel), .o_valid(o_valid), .o_format(o_format),
    .o_len_hw(o_len_hw), .o_opcode(o_opcode), .o_first_sel(o_first_sel),
    .o_second_sel(o_second_sel), .o_use_second(o_use_second), .o_short_imm(o_short_imm),
    .o_ea(o_ea), .o_ea_valid(o_ea_valid),
    .o_cond_branch(o_cond_branch), .o_branch_mask(o_branch_mask),
    .o_branch_take(o_branch_take));
  ifd_xreg_model xregs (.i_sel(o_x_sel), .i_bias(bias), .o_data(xdata));

  // ****************************************************************
  // Helpers that work out what the decoder should answer
  // ****************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic ifd_fmt_t fmt_of(input logic [31:0] w);
    logic [7:0] op;
    op = w[31:24];
    if (op >= IFD_SHORT_LO && op <= IFD_SHORT_HI) return IFD_FMT_SHORT;
    if (op < IFD_RX_LO) return IFD_FMT_REGREG;
    if (op <= IFD_RX_HI) begin
      if (w[IFD_B16]) return IFD_FMT_IDXREL;
      if (!w[IFD_B17]) return IFD_FMT_IDXABS;
      return (w[13:12] == 2'h0) ? IFD_FMT_DBLIDX : IFD_FMT_ILL;
    end
    return (op >= IFD_RI2_LO) ? IFD_FMT_RI2 : IFD_FMT_RI1;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The index value is the register model's pattern unless the field is zero.
  task automatic compare(input ifd_tb_item_t it);
    ifd_fmt_t    f;
    logic [31:0] x, ea;
    logic        cb;
    logic [1:0]  ln;
    f = fmt_of(it.ins);
    ln = (f inside {IFD_FMT_REGREG, IFD_FMT_SHORT, IFD_FMT_ILL}) ? IFD_LEN_1HW :
         (f inside {IFD_FMT_DBLIDX, IFD_FMT_RI2}) ? IFD_LEN_3HW : IFD_LEN_2HW;
    x = (it.ins[19:16] == 4'h0) ? 32'h0 : (it.bias ^ {28'h0, it.ins[19:16]});
    ea = 32'h0;
    if (f == IFD_FMT_IDXABS) ea = x + {18'h0, it.ins[13:0]};
    if (f == IFD_FMT_IDXREL)
      ea = x + {{17{it.ins[14]}}, it.ins[14:0]} + {it.loc[31:1], 1'b0} + 32'h4;
    cb = it.ins[31:24] inside {IFD_CBR_REG, IFD_CBR_SHORT, IFD_CBR_RXT, IFD_CBR_RXF};
    check("valid", o_valid, it.vld);
    if (it.vld) begin
      check("format", o_format, f);
      check("length", o_len_hw, ln);
      check("opcode", o_opcode, it.ins[31:24]);
      check("first_sel", o_first_sel, it.ins[23:20]);
      check("second_sel", o_second_sel, it.ins[19:16]);
      check("use_second", o_use_second, f == IFD_FMT_REGREG);
      check("imm", o_short_imm, (f == IFD_FMT_SHORT) ? {28'h0, it.ins[19:16]} : 32'h0);
      check("ea", o_ea, ea);
      check("ea_valid", o_ea_valid, f inside {IFD_FMT_IDXABS, IFD_FMT_IDXREL});
      check("cbranch", o_cond_branch, cb);
      check("mask", o_branch_mask, cb ? it.ins[23:20] : 4'h0);
      check("take", o_branch_take, cb && ((it.ins[23:20] & it.cc) != 4'h0));
    end
  endtask

  // One word per falling edge; results come back two falling edges later, and the
  // index select of the previous word stands one falling edge after it was driven.
  task automatic step(input logic v, input logic [31:0] w, input logic [31:0] l);
    @(negedge i_mclk);
    if (q.size() == 2) compare(q.pop_front());
    if (q.size() > 0) check("x_sel", o_x_sel, {28'h0, q[q.size() - 1].ins[19:16]});
    lfsr = nxt(lfsr);
    i_cc = lfsr[3:0];
    if (q.size() > 0) q[q.size() - 1].cc = i_cc;
    i_valid = v;
    i_instr = w;
    i_loc = l;
    q.push_back('{v, w, l, bias, 4'h0});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // Should the stimulus ever run past 2000 clocks, count a failure and cut the run short.
  initial begin
    repeat (2000) @(posedge i_mclk);
    n_fail++;
    close_out();
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    lfsr = 32'h28585e5e;
    bias = 32'h8;
    i_reset = 1'b1;
    i_valid = 1'b0;
    i_instr = 32'h0;
    i_loc = 32'h0;
    i_cc = 4'h0;
    repeat (16) @(negedge i_mclk);
    check("reset format", o_format, IFD_FMT_ILL);
    check("reset valid", o_valid, 1'b0);
    i_reset = 1'b0;
    for (int i = 0; i < 16; i++) step(1'b1, EX_W[i], EX_L[i]);
    repeat (3) step(1'b0, 32'h0, 32'h0);
    $display("test examples done");
    lfsr = nxt(lfsr);
    bias = lfsr;
    for (int i = 0; i < 400; i++) begin
      lfsr = nxt(lfsr);
      step(lfsr[0] | lfsr[1], nxt(lfsr) ^ lfsr, {lfsr[15:0], lfsr[31:16]});
    end
    repeat (3) step(1'b0, 32'h0, 32'h0);
    $display("test random done");
    close_out();
  end
endmodule

`default_nettype wire
